// ### rtl/irq_bank_pkg.sv
// Constants, field positions and helpers for the interrupt flag/enable bank.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package irq_bank_pkg;

    //--------------------------------------------------------------
    // Bus geometry
    //--------------------------------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned STRB_W = 4;
    localparam int unsigned REG_W  = 16;

    //--------------------------------------------------------------
    // Register map (byte addresses)
    //--------------------------------------------------------------
    localparam logic [ADDR_W-1:0] FLAGS_GROUP4_ADDR   = 12'h000;
    localparam logic [ADDR_W-1:0] FLAGS_GROUP5_ADDR   = 12'h004;
    localparam logic [ADDR_W-1:0] ENABLES_GROUP0_ADDR = 12'h008;
    localparam logic [ADDR_W-1:0] WORD_ALIGN_MASK     = 12'hFFC;
    localparam logic [REG_W-1:0]  REG_RESET           = 16'h0000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    //--------------------------------------------------------------
    // Flag group 4 positions
    //--------------------------------------------------------------
    localparam int unsigned CHARGE_TIME_UNIT_FLAG_BIT  = 13;
    localparam int unsigned LOW_VOLTAGE_DETECT_FLAG_BIT = 8;
    localparam int unsigned CRC_GENERATOR_FLAG_BIT     = 3;
    localparam int unsigned UART2_ERROR_FLAG_BIT       = 2;
    localparam int unsigned UART1_ERROR_FLAG_BIT       = 1;

    //--------------------------------------------------------------
    // Flag group 5 positions
    //--------------------------------------------------------------
    localparam int unsigned CAPTURE9_FLAG_BIT          = 13;
    localparam int unsigned COMPARE9_FLAG_BIT          = 12;
    localparam int unsigned SPI3_EVENT_FLAG_BIT        = 11;
    localparam int unsigned SPI3_FAULT_FLAG_BIT        = 10;
    localparam int unsigned UART4_TRANSMIT_FLAG_BIT    = 9;
    localparam int unsigned UART4_RECEIVE_FLAG_BIT     = 8;
    localparam int unsigned UART4_ERROR_FLAG_BIT       = 7;
    localparam int unsigned I2C3_MASTER_EVENT_FLAG_BIT = 5;
    localparam int unsigned I2C3_SLAVE_EVENT_FLAG_BIT  = 4;
    localparam int unsigned UART3_TRANSMIT_FLAG_BIT    = 3;
    localparam int unsigned UART3_RECEIVE_FLAG_BIT     = 2;
    localparam int unsigned UART3_ERROR_FLAG_BIT       = 1;

    //--------------------------------------------------------------
    // Enable group 0 positions
    //--------------------------------------------------------------
    localparam int unsigned ADC_COMPLETE_ENABLE_BIT  = 13;
    localparam int unsigned UART1_TRANSMIT_ENABLE_BIT = 12;
    localparam int unsigned UART1_RECEIVE_ENABLE_BIT = 11;
    localparam int unsigned SPI1_TRANSFER_ENABLE_BIT = 10;
    localparam int unsigned SPI1_FAULT_ENABLE_BIT    = 9;
    localparam int unsigned TIMER3_ENABLE_BIT        = 8;
    localparam int unsigned TIMER2_ENABLE_BIT        = 7;
    localparam int unsigned COMPARE2_ENABLE_BIT      = 6;
    localparam int unsigned CAPTURE2_ENABLE_BIT      = 5;
    localparam int unsigned TIMER1_ENABLE_BIT        = 3;
    localparam int unsigned COMPARE1_ENABLE_BIT      = 2;
    localparam int unsigned CAPTURE1_ENABLE_BIT      = 1;
    localparam int unsigned EXTERNAL_IRQ0_ENABLE_BIT = 0;

    //--------------------------------------------------------------
    // Implemented-bit masks built from the positions
    //--------------------------------------------------------------
    localparam logic [REG_W-1:0] ONE_BIT = 16'h0001;
    localparam logic [REG_W-1:0] FLAGS_GROUP4_MASK =
        (ONE_BIT << CHARGE_TIME_UNIT_FLAG_BIT) | (ONE_BIT << LOW_VOLTAGE_DETECT_FLAG_BIT) |
        (ONE_BIT << CRC_GENERATOR_FLAG_BIT) | (ONE_BIT << UART2_ERROR_FLAG_BIT) |
        (ONE_BIT << UART1_ERROR_FLAG_BIT);
    localparam logic [REG_W-1:0] FLAGS_GROUP5_MASK =
        (ONE_BIT << CAPTURE9_FLAG_BIT) | (ONE_BIT << COMPARE9_FLAG_BIT) |
        (ONE_BIT << SPI3_EVENT_FLAG_BIT) | (ONE_BIT << SPI3_FAULT_FLAG_BIT) |
        (ONE_BIT << UART4_TRANSMIT_FLAG_BIT) | (ONE_BIT << UART4_RECEIVE_FLAG_BIT) |
        (ONE_BIT << UART4_ERROR_FLAG_BIT) | (ONE_BIT << I2C3_MASTER_EVENT_FLAG_BIT) |
        (ONE_BIT << I2C3_SLAVE_EVENT_FLAG_BIT) | (ONE_BIT << UART3_TRANSMIT_FLAG_BIT) |
        (ONE_BIT << UART3_RECEIVE_FLAG_BIT) | (ONE_BIT << UART3_ERROR_FLAG_BIT);
    localparam logic [REG_W-1:0] ENABLES_GROUP0_MASK =
        (ONE_BIT << ADC_COMPLETE_ENABLE_BIT) | (ONE_BIT << UART1_TRANSMIT_ENABLE_BIT) |
        (ONE_BIT << UART1_RECEIVE_ENABLE_BIT) | (ONE_BIT << SPI1_TRANSFER_ENABLE_BIT) |
        (ONE_BIT << SPI1_FAULT_ENABLE_BIT) | (ONE_BIT << TIMER3_ENABLE_BIT) |
        (ONE_BIT << TIMER2_ENABLE_BIT) | (ONE_BIT << COMPARE2_ENABLE_BIT) |
        (ONE_BIT << CAPTURE2_ENABLE_BIT) | (ONE_BIT << TIMER1_ENABLE_BIT) |
        (ONE_BIT << COMPARE1_ENABLE_BIT) | (ONE_BIT << CAPTURE1_ENABLE_BIT) |
        (ONE_BIT << EXTERNAL_IRQ0_ENABLE_BIT);

    //--------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------
    // Register selected by a bus address
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_FLAGS4,
        SEL_FLAGS5,
        SEL_ENABLES0
    } reg_sel_type;

    function automatic reg_sel_type reg_select(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] word;
        word = addr & WORD_ALIGN_MASK;
        if (word == FLAGS_GROUP4_ADDR) begin
            return SEL_FLAGS4;
        end else if (word == FLAGS_GROUP5_ADDR) begin
            return SEL_FLAGS5;
        end else if (word == ENABLES_GROUP0_ADDR) begin
            return SEL_ENABLES0;
        end else begin
            return SEL_NONE;
        end
    endfunction

    // Byte-lane merge of a write into a 16-bit register
    function automatic logic [REG_W-1:0] merge_bytes(input logic [REG_W-1:0] old,
                                                     input logic [DATA_W-1:0] wdata,
                                                     input logic [STRB_W-1:0] strb);
        logic [REG_W-1:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction

endpackage

// ### rtl/regbus_if.sv
// Internal register-access carrier between the bus slave and the bank.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface regbus_if;
    import irq_bank_pkg::*;
    logic                wr_en;
    logic [ADDR_W-1:0]   wr_addr;
    logic [DATA_W-1:0]   wr_data;
    logic [STRB_W-1:0]   wr_strb;
    logic                wr_err;
    logic                rd_en;
    logic [ADDR_W-1:0]   rd_addr;
    logic [DATA_W-1:0]   rd_data;
    logic                rd_err;

    modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                  input  wr_err, rd_data, rd_err);
    modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                  output wr_err, rd_data, rd_err);
endinterface
`default_nettype wire

// ### rtl/axil_reg_slave.sv
// AXI4-Lite slave: handshakes, one write and one read in flight.
// Assumes the register side answers decode and read data combinationally.
`timescale 1ns/1ns
`default_nettype none
module axil_reg_slave
    import irq_bank_pkg::*;
(
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    input  wire logic [irq_bank_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [irq_bank_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [irq_bank_pkg::STRB_W-1:0] s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [irq_bank_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [irq_bank_pkg::DATA_W-1:0]   s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    regbus_if.bus                             bus
);
    typedef struct packed {
        logic              aw_held;
        logic              w_held;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [STRB_W-1:0] strb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } slave_state_type;

    slave_state_type s_q;
    slave_state_type s_d;

    // Write fires once both halves are held and no response is pending
    assign bus.wr_en   = s_q.aw_held & s_q.w_held & ~s_q.bvalid;
    assign bus.wr_addr = s_q.addr;
    assign bus.wr_data = s_q.data;
    assign bus.wr_strb = s_q.strb;
    assign bus.rd_en   = s_axi_arvalid & s_q.arready;
    assign bus.rd_addr = s_axi_araddr;

    // Next state; address and data may arrive in either order
    always_comb begin
        s_d = s_q;
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_held = 1'b1;
            s_d.addr    = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_held = 1'b1;
            s_d.data   = s_axi_wdata;
            s_d.strb   = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (bus.wr_en) begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = bus.wr_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (bus.rd_en) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = bus.rd_data;
            s_d.rresp  = bus.rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        // Readies registered so every AXI output leaves a flop
        s_d.awready = ~s_d.aw_held & ~s_d.bvalid;
        s_d.wready  = ~s_d.w_held & ~s_d.bvalid;
        s_d.arready = ~s_d.rvalid;
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready  = s_q.wready;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;
endmodule // axil_reg_slave
`default_nettype wire

// ### rtl/irq_req_gate.sv
// Registered AND of flags with enables for one 16-bit source group.
// Assumes both vectors are already on aclk.
`timescale 1ns/1ns
`default_nettype none
module irq_req_gate
    import irq_bank_pkg::*;
(
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [irq_bank_pkg::REG_W-1:0] flags,
    input  wire logic [irq_bank_pkg::REG_W-1:0] enables,
    output logic [irq_bank_pkg::REG_W-1:0]   requests
);
    typedef struct packed {
        logic [REG_W-1:0] req;
    } gate_state_type;

    gate_state_type s_q;
    gate_state_type s_d;

    // Forward only where flag and enable are both set
    always_comb begin
        s_d     = s_q;
        s_d.req = flags & enables;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign requests = s_q.req;
endmodule // irq_req_gate
`default_nettype wire

// ### rtl/irq_flag_enable_bank.sv
// Flag groups 4 and 5 and enable group 0 of the interrupt controller.
// Assumes event pulses, foreign enables and foreign flags arrive on aclk.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module irq_flag_enable_bank
    import irq_bank_pkg::*;
(
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    input  wire logic [irq_bank_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [irq_bank_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [irq_bank_pkg::STRB_W-1:0] s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    input  wire logic [irq_bank_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [irq_bank_pkg::DATA_W-1:0]     s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    input  wire logic [irq_bank_pkg::REG_W-1:0] source_events4,
    input  wire logic [irq_bank_pkg::REG_W-1:0] source_events5,
    input  wire logic [irq_bank_pkg::REG_W-1:0] enables_group4,
    input  wire logic [irq_bank_pkg::REG_W-1:0] enables_group5,
    input  wire logic [irq_bank_pkg::REG_W-1:0] flags_group0,
    output logic [irq_bank_pkg::REG_W-1:0]      flags_group4_out,
    output logic [irq_bank_pkg::REG_W-1:0]      flags_group5_out,
    output logic [irq_bank_pkg::REG_W-1:0]      enables_group0_out,
    output logic [irq_bank_pkg::REG_W-1:0]      requests_group4,
    output logic [irq_bank_pkg::REG_W-1:0]      requests_group5,
    output logic [irq_bank_pkg::REG_W-1:0]      requests_group0
);
    //----------------------------------------------------------------
    // State
    //----------------------------------------------------------------
    typedef struct packed {
        logic [REG_W-1:0] flags4;
        logic [REG_W-1:0] flags5;
        logic [REG_W-1:0] enables0;
    } bank_state_type;

    bank_state_type s_q;
    bank_state_type s_d;
    reg_sel_type    wr_sel;
    reg_sel_type    rd_sel;

    regbus_if rbus ();

    //----------------------------------------------------------------
    // Bus slave
    //----------------------------------------------------------------
    axil_reg_slave u_slave (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .bus           (rbus)
    );

    //----------------------------------------------------------------
    // Address decode
    //----------------------------------------------------------------
    // Unmapped words answer SLVERR; their writes change nothing
    assign wr_sel      = reg_select(rbus.wr_addr);
    assign rd_sel      = reg_select(rbus.rd_addr);
    assign rbus.wr_err = (wr_sel == SEL_NONE);
    assign rbus.rd_err = (rd_sel == SEL_NONE);

    // Read mux; upper half-word and unused positions read zero
    always_comb begin
        rbus.rd_data = '0;
        case (rd_sel)
            SEL_FLAGS4:   rbus.rd_data[REG_W-1:0] = s_q.flags4 & FLAGS_GROUP4_MASK;
            SEL_FLAGS5:   rbus.rd_data[REG_W-1:0] = s_q.flags5 & FLAGS_GROUP5_MASK;
            SEL_ENABLES0: rbus.rd_data[REG_W-1:0] = s_q.enables0 & ENABLES_GROUP0_MASK;
            default:      rbus.rd_data = '0;
        endcase
    end

    //----------------------------------------------------------------
    // Register update
    //----------------------------------------------------------------
    // Source events OR in after the software write so a set in the
    // same cycle as a clearing write is never lost
    always_comb begin
        s_d = s_q;
        if (rbus.wr_en && wr_sel == SEL_FLAGS4) begin
            s_d.flags4 = merge_bytes(s_q.flags4, rbus.wr_data, rbus.wr_strb);
        end
        if (rbus.wr_en && wr_sel == SEL_FLAGS5) begin
            s_d.flags5 = merge_bytes(s_q.flags5, rbus.wr_data, rbus.wr_strb);
        end
        if (rbus.wr_en && wr_sel == SEL_ENABLES0) begin
            s_d.enables0 = merge_bytes(s_q.enables0, rbus.wr_data, rbus.wr_strb);
        end
        s_d.flags4 = (s_d.flags4 | source_events4) & FLAGS_GROUP4_MASK;
        s_d.flags5 = (s_d.flags5 | source_events5) & FLAGS_GROUP5_MASK;
        s_d.enables0 = s_d.enables0 & ENABLES_GROUP0_MASK;
    end

    // Synchronous reset to all-zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q.flags4   <= REG_RESET;
            s_q.flags5   <= REG_RESET;
            s_q.enables0 <= REG_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    //----------------------------------------------------------------
    // Request gating
    //----------------------------------------------------------------
    // One cycle of latency; traded for flop-driven outputs
    irq_req_gate u_gate4 (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .flags    (s_q.flags4),
        .enables  (enables_group4 & FLAGS_GROUP4_MASK),
        .requests (requests_group4)
    );

    irq_req_gate u_gate5 (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .flags    (s_q.flags5),
        .enables  (enables_group5 & FLAGS_GROUP5_MASK),
        .requests (requests_group5)
    );

    // Enable 0 gates the flags kept in another bank
    irq_req_gate u_gate0 (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .flags    (flags_group0),
        .enables  (s_q.enables0),
        .requests (requests_group0)
    );

    // State outputs for the rest of the controller
    assign flags_group4_out   = s_q.flags4;
    assign flags_group5_out   = s_q.flags5;
    assign enables_group0_out = s_q.enables0;
endmodule // irq_flag_enable_bank
`default_nettype wire

// ### tb/irq_source_model.sv
// Peripheral sources: event pulses plus foreign enables and flags.
// Assumes one bench process calls its tasks, on aclk.
`timescale 1ns/1ns
`default_nettype none
module irq_source_model (
    input  wire logic  aclk,
    output logic [15:0] source_events4, source_events5,
    output logic [15:0] enables_group4, enables_group5, flags_group0
);
    // Quiet sources until told otherwise
    initial begin
        {source_events4, source_events5, enables_group4, enables_group5, flags_group0} = '0;
    end
    // One-cycle request from each selected source
    task automatic pulse(input logic [15:0] e4, e5);
        @(posedge aclk);
        {source_events4, source_events5} <= {e4, e5};
        @(posedge aclk);
        {source_events4, source_events5} <= '0;
    endtask
    // Levels held by the other enable and flag groups
    task automatic levels(input logic [15:0] e4, e5, f0);
        @(posedge aclk);
        {enables_group4, enables_group5, flags_group0} <= {e4, e5, f0};
    endtask
endmodule // irq_source_model
`default_nettype wire

// ### tb/irq_bank_props.sv
// Checker: bus timing, reset, flag setting and request gating.
// Assumes a bind to the bank top; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module irq_bank_props
    import irq_bank_pkg::*;
(
    input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    input wire logic        s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [15:0] source_events4, source_events5, enables_group4, flags_group0,
    input wire logic [15:0] flags_group4_out, flags_group5_out, enables_group0_out,
    input wire logic [15:0] requests_group4, requests_group0
);
    // Events as the groups see them; unused positions drop out
    logic [15:0] ev4, ev5;
    assign ev4 = source_events4 & FLAGS_GROUP4_MASK;
    assign ev5 = source_events5 & FLAGS_GROUP5_MASK;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Accepted requests on the bus
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
    wr_resp_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    rd_resp_a: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    rd_unmapped_a: assert property (rd_taken ##0 s_axi_araddr[11:2] > 10'h002 |=>
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000) else $error("bad unmapped");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper half not zero");
    unused_zero_a: assert property (((flags_group4_out & ~FLAGS_GROUP4_MASK) |
        (flags_group5_out & ~FLAGS_GROUP5_MASK) | (enables_group0_out & ~ENABLES_GROUP0_MASK))
        == 16'h0000) else $error("unused bit set");
    event_set_a: assert property ((ev4 | ev5) != 16'h0000 |=>
        (flags_group4_out & $past(ev4)) == $past(ev4) && (flags_group5_out & $past(ev5))
        == $past(ev5)) else $error("event lost");
    req_gate_a: assert property (requests_group4 == ($past(flags_group4_out) &
        $past(enables_group4)) && requests_group0 == ($past(flags_group0) &
        $past(enables_group0_out))) else $error("bad gate");
    reset_clear_a: assert property (disable iff (1'b0) !aresetn |=> (flags_group4_out |
        flags_group5_out | enables_group0_out | requests_group4) == 16'h0000)
        else $error("reset left state");
endmodule // irq_bank_props
bind irq_flag_enable_bank irq_bank_props u_irq_bank_props (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .s_axi_araddr,
    .s_axi_rdata, .source_events4, .source_events5, .enables_group4, .flags_group0,
    .flags_group4_out, .flags_group5_out, .enables_group0_out, .requests_group4,
    .requests_group0
);
`default_nettype wire

// ### tb/irq_flag_enable_bank_test.sv
// Bench: register access over AXI4-Lite plus source events.
// Assumes the source model beside the bank and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module irq_flag_enable_bank_test;
    import irq_bank_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] source_events4, source_events5, enables_group4, enables_group5, flags_group0;
    logic [15:0] flags_group4_out, flags_group5_out, enables_group0_out;
    logic [15:0] requests_group4, requests_group5, requests_group0;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    irq_flag_enable_bank u_irq_flag_enable_bank (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .source_events4, .source_events5, .enables_group4, .enables_group5,
        .flags_group0, .flags_group4_out, .flags_group5_out, .enables_group0_out,
        .requests_group4, .requests_group5, .requests_group0
    );
    irq_source_model u_irq_source_model (
        .aclk, .source_events4, .source_events5, .enables_group4, .enables_group5, .flags_group0
    );
    // 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Compare and count
    task automatic chk(input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Write: address and data together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        logic aw_ok, w_ok;
        {aw_ok, w_ok} = 2'b00;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            aw_ok = aw_ok | s_axi_awready;
            w_ok = w_ok | s_axi_wready;
            {s_axi_awvalid, s_axi_wvalid} <= {!aw_ok, !w_ok};
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, r);
    endtask
    // Read: hold the request until taken, then wait for the answer
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, r);
    endtask
    task automatic rd3(input logic [15:0] f4, f5, e0);
        rd(FLAGS_GROUP4_ADDR, f4, RESP_OKAY);
        rd(FLAGS_GROUP5_ADDR, f5, RESP_OKAY);
        rd(ENABLES_GROUP0_ADDR, e0, RESP_OKAY);
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            wrap_up();
        end
    end
    // Tests; the all-ones read-back gives every field position
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd3(16'h0000, 16'h0000, 16'h0000);
        rd(12'h00C, 32'h00000000, RESP_SLVERR);
        for (int i = 0; i < 3; i++) wr(12'(4 * i), 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        rd3(16'h210E, 16'h3FBE, 16'h3FEF);
        wr(ENABLES_GROUP0_ADDR, 32'h00000000, 4'h1, RESP_OKAY);
        wr(FLAGS_GROUP4_ADDR, 32'h00000000, 4'hF, RESP_OKAY);
        wr(FLAGS_GROUP5_ADDR, 32'h00000000, 4'hF, RESP_OKAY);
        wr(12'h010, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
        rd3(16'h0000, 16'h0000, 16'h3F00);
        u_irq_source_model.levels(16'hFFFF, 16'h00FF, 16'hFFFF);
        u_irq_source_model.pulse(16'hFFFF, 16'hFFFF);
        rd3(16'h210E, 16'h3FBE, 16'h3F00);
        @(negedge aclk);
        chk(requests_group4, 16'h210E);
        chk(requests_group5, 16'h00BE);
        chk(requests_group0, 16'h3F00);
        wr(ENABLES_GROUP0_ADDR, 32'h00000000, 4'h3, RESP_OKAY);
        repeat (2) @(negedge aclk);
        chk(requests_group0, 16'h0000);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd3(16'h0000, 16'h0000, 16'h0000);
        wrap_up();
    end
endmodule // irq_flag_enable_bank_test
`default_nettype wire
